// *** tb/bcr_relay_sva.sv ***
// port assertions for the capability relay
// assumes CE stays high so answer latencies hold
`timescale 1ns/10ps
module bcr_relay_chk #(
   parameter int NPORT = 2,
   parameter int TXN_CYC = 50
) (
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic CE,
   input wire logic REQ_VALID,
   input wire bcr_pkg::bcr_req_t REQ,
   input wire logic [NPORT-1:0] DS_PRESENT,
   input wire bcr_pkg::bcr_cap_t OWN_CAP,
   input wire logic RD_VALID,
   input wire logic DONE,
   input wire bcr_pkg::bcr_resp_t RESP,
   input wire logic BUSY,
   input wire bcr_pkg::bcr_cap_t ADV_CAP,
   input wire bcr_pkg::bcr_cap_t LINK_CFG
);
   logic take;
   logic len_ok;
   assign take = CE && REQ_VALID && !BUSY;
   assign len_ok = REQ.len != 5'h00 && REQ.len <= 5'h10;
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_B);
   a_bad_len: assert property (
      take && !len_ok |-> ##2 DONE && RESP == bcr_pkg::BCR_NACK)
      else $error("bad burst length not refused");
   a_txn_bound: assert property (
      take |-> ##[2:60] DONE) else $error("transaction never ended");
   a_read_first: assert property (
      take && len_ok && !REQ.wr && !REQ.id_space |-> ##2 RD_VALID && BUSY)
      else $error("first read byte late");
   a_busy_take: assert property (
      take |=> BUSY ##1 (BUSY || DONE))
      else $error("busy missing after take");
   a_id_nack: assert property (
      take && len_ok && REQ.id_space && !REQ.wr && DS_PRESENT == '0 &&
      $past(DS_PRESENT) == '0 && $past(DS_PRESENT, 3) == '0
      |-> ##2 DONE && RESP == bcr_pkg::BCR_NACK)
      else $error("id read not refused");
   a_adv_lesser: assert property (
      ADV_CAP.lanes <= OWN_CAP.lanes && ADV_CAP.rate <= OWN_CAP.rate)
      else $error("advertised above own ability");
   a_lane_codes: assert property (
      LINK_CFG.lanes inside {5'h01, 5'h02, 5'h04} &&
      ADV_CAP.lanes inside {5'h01, 5'h02, 5'h04})
      else $error("illegal lane count");
   a_rate_codes: assert property (
      LINK_CFG.rate inside {8'h06, 8'h0A} &&
      ADV_CAP.rate inside {8'h06, 8'h0A})
      else $error("illegal link rate");
   c_id_read: cover property (take && REQ.id_space && !REQ.wr);
   c_nack: cover property (DONE && RESP == bcr_pkg::BCR_NACK);
   c_two_lane: cover property (ADV_CAP.lanes == 5'h02);
endmodule
bind bcr_relay bcr_relay_chk #(.NPORT(NPORT), .TXN_CYC(TXN_CYC)) i_chk (
   .CLK(CLK), .RST_B(RST_B), .CE(CE), .REQ_VALID(REQ_VALID), .REQ(REQ),
   .DS_PRESENT(DS_PRESENT), .OWN_CAP(OWN_CAP), .RD_VALID(RD_VALID),
   .DONE(DONE), .RESP(RESP), .BUSY(BUSY), .ADV_CAP(ADV_CAP),
   .LINK_CFG(LINK_CFG));

// *** tb/bcr_src_model.sv ***
// upstream source model: one whole aux request at a time
// assumes requests are taken on the rising edge while BUSY is low
`timescale 1ns/10ps
module bcr_src_model (
   input wire logic CLK,
   input wire logic DONE,
   input wire logic RD_VALID,
   input wire logic [7:0] RD_DATA,
   input wire bcr_pkg::bcr_resp_t RESP,
   output logic REQ_VALID,
   output bcr_pkg::bcr_req_t REQ,
   output logic [7:0] WR_DATA
);
   logic [7:0] rd_q [$];
   bcr_pkg::bcr_resp_t resp;
   initial begin
      REQ_VALID = 1'b0;
      REQ = '0;
      WR_DATA = 8'h00;
   end
   // next request only after done; topology never asked
   task automatic xfer(input logic [19:0] adr, input logic [4:0] len,
      input logic wr, input logic id, input logic [7:0] wd);
      bit got;
      rd_q.delete();
      resp = bcr_pkg::bcr_resp_t'(2'h3);
      @(negedge CLK);
      REQ = '{adr, len, wr, id};
      WR_DATA = wd;
      REQ_VALID = 1'b1;
      @(negedge CLK);
      REQ_VALID = 1'b0;
      // stale values would hide a late sample
      REQ = bcr_pkg::bcr_req_t'(~REQ);
      // sample on the falling edge, clear of the rising-edge update
      for (int n = 0; n < 100 && !got; n++) begin
         @(negedge CLK);
         if (RD_VALID === 1'b1) begin
            rd_q.push_back(RD_DATA);
         end
         if (DONE === 1'b1) begin
            resp = RESP;
            got = 1'b1;
         end
      end
      WR_DATA = ~WR_DATA;
   endtask
endmodule

// *** tb/tb_bcr_relay.sv ***
// self-checking bench for the capability relay
// assumes the source model and checker are compiled before it
`timescale 1ns/10ps
module tb_bcr_relay;
   logic CLK, RST_B, CE, ID_WE, REQ_VALID, RD_VALID, DONE, BUSY;
   logic [7:0] RD_DATA, WR_DATA, ID_WDATA;
   logic [1:0] DS_PRESENT;
   logic [6:0] ID_WADR;
   logic [0:0] DS_SEL;
   bcr_pkg::bcr_req_t REQ;
   bcr_pkg::bcr_resp_t RESP;
   bcr_pkg::bcr_cap_t OWN_CAP, ADV_CAP, LINK_CFG;
   bcr_pkg::bcr_cap_t [1:0] DS_CAP;
   int n_errors = 0;
   int tests_run = 0;
   // short window so a full burst runs out of time
   localparam int TXN = 8;
   bcr_relay #(.NPORT(2), .TXN_CYC(TXN)) i_dut (.CLK(CLK), .RST_B(RST_B),
      .CE(CE), .REQ_VALID(REQ_VALID), .REQ(REQ), .WR_DATA(WR_DATA),
      .DS_PRESENT(DS_PRESENT), .OWN_CAP(OWN_CAP), .DS_CAP(DS_CAP),
      .ID_WE(ID_WE), .ID_WADR(ID_WADR), .ID_WDATA(ID_WDATA),
      .RD_VALID(RD_VALID), .RD_DATA(RD_DATA), .DONE(DONE), .RESP(RESP),
      .BUSY(BUSY), .ADV_CAP(ADV_CAP), .LINK_CFG(LINK_CFG), .DS_SEL(DS_SEL));
   bcr_src_model i_src (.CLK(CLK), .DONE(DONE), .RD_VALID(RD_VALID),
      .RD_DATA(RD_DATA), .RESP(RESP), .REQ_VALID(REQ_VALID), .REQ(REQ),
      .WR_DATA(WR_DATA));
   initial begin
      CLK = 1'b0;
      forever #4 CLK = ~CLK;
   end
   task automatic bad(input logic [12:0] e, input logic [12:0] g);
      n_errors++;
      $display("unexpected %0t exp %h got %h", $time, e, g);
   endtask
   task automatic chk_byte(input logic [7:0] e, input logic [7:0] g);
      tests_run++;
      if (g !== e) bad(e, g);
   endtask
   task automatic chk_cap(input bcr_pkg::bcr_cap_t e, bcr_pkg::bcr_cap_t g);
      tests_run++;
      if (g !== e) bad(e, g);
   endtask
   task automatic chk_resp(input bcr_pkg::bcr_resp_t e);
      tests_run++;
      if (i_src.resp !== e) bad(e, i_src.resp);
   endtask
   // ------------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------------
   task automatic t_reset;
      chk_cap({8'h06, 5'h01}, ADV_CAP);
      chk_cap({8'h06, 5'h01}, LINK_CFG);
      chk_byte(8'h00, {7'h00, DS_SEL});
      RST_B = 1'b1;
      repeat (4) @(negedge CLK);
      chk_cap({8'h0A, 5'h04}, ADV_CAP);
      i_src.xfer(20'h00001, 5'h02, 1'b0, 1'b0, 8'h00);
      chk_resp(bcr_pkg::BCR_ACK);
      chk_byte(8'h0A, i_src.rd_q[0]);
      chk_byte(8'h04, i_src.rd_q[1]);
      $display("test reset_and_cap done");
   endtask
   task automatic t_refuse;
      logic [4:0] ln [3] = '{5'h00, 5'h11, 5'h01};
      for (int i = 0; i < 3; i++) begin
         i_src.xfer(20'h00000, ln[i], 1'b0, i == 2, 8'h00);
         chk_resp(bcr_pkg::BCR_NACK);
         chk_byte(8'h00, 8'(i_src.rd_q.size()));
      end
      $display("test refuse done");
   endtask
   task automatic t_cfg;
      logic [7:0] d [6] = '{8'h0A, 8'h01, 8'h02, 8'h04, 8'h03, 8'h07};
      logic [4:0] e [6] = '{5'h01, 5'h01, 5'h02, 5'h04, 5'h04, 5'h04};
      for (int i = 0; i < 6; i++) begin
         i_src.xfer(i inside {0, 5} ? 20'h00100 : 20'h00101, 5'h01, 1'b1,
            1'b0, d[i]);
         chk_cap({8'h0A, e[i]}, LINK_CFG);
      end
      $display("test link_config done");
   endtask
   task automatic t_vendor;
      for (int i = 0; i < 2; i++) begin
         i_src.xfer(i ? 20'h003FF : 20'h00300, 5'h01, 1'b1, 1'b0, 8'h5A + i);
         i_src.xfer(i ? 20'h003FF : 20'h00300, 5'h01, 1'b0, 1'b0, 8'h00);
         chk_byte(8'h5A + i, i_src.rd_q[0]);
      end
      $display("test vendor done");
   endtask
   task automatic t_merge;
      DS_PRESENT = 2'h1;
      repeat (5) @(negedge CLK);
      chk_cap({8'h0A, 5'h02}, ADV_CAP);
      i_src.xfer(20'h00002, 5'h01, 1'b0, 1'b0, 8'h00);
      chk_byte(8'h02, i_src.rd_q[0]);
      DS_PRESENT = 2'h3;
      repeat (5) @(negedge CLK);
      chk_byte(8'h00, {7'h00, DS_SEL});
      DS_PRESENT = 2'h2;
      repeat (5) @(negedge CLK);
      chk_byte(8'h01, {7'h00, DS_SEL});
      chk_cap({8'h06, 5'h04}, ADV_CAP);
      for (int i = 0; i < 2; i++) begin
         ID_WE = 1'b1;
         ID_WADR = 7'(i);
         ID_WDATA = 8'hC3 + i;
         @(negedge CLK);
      end
      ID_WE = 1'b0;
      i_src.xfer(20'h00000, 5'h02, 1'b0, 1'b1, 8'h00);
      chk_resp(bcr_pkg::BCR_ACK);
      chk_byte(8'hC3, i_src.rd_q[0]);
      chk_byte(8'hC4, i_src.rd_q[1]);
      $display("test merge_and_id done");
   endtask
   task automatic t_freeze;
      CE = 1'b0;
      DS_PRESENT = 2'h1;
      repeat (5) @(negedge CLK);
      chk_byte(8'h01, {7'h00, DS_SEL});
      chk_cap({8'h06, 5'h04}, ADV_CAP);
      CE = 1'b1;
      repeat (5) @(negedge CLK);
      chk_byte(8'h00, {7'h00, DS_SEL});
      chk_cap({8'h0A, 5'h02}, ADV_CAP);
      $display("test freeze done");
   endtask
   task automatic t_defer;
      // one byte per cycle until the window closes
      i_src.xfer(20'h00300, 5'h10, 1'b0, 1'b0, 8'h00);
      chk_resp(bcr_pkg::BCR_DEFER);
      chk_byte(8'(TXN), 8'(i_src.rd_q.size()));
      chk_byte(8'h5A, i_src.rd_q[0]);
      i_src.xfer(20'h00101, 5'h01, 1'b0, 1'b0, 8'h00);
      chk_resp(bcr_pkg::BCR_ACK);
      chk_byte(8'h04, i_src.rd_q[0]);
      $display("test defer done");
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      #40000;
      n_errors++;
      finish_test;
   end
   initial begin
      RST_B = 1'b0;
      CE = 1'b1;
      ID_WE = 1'b0;
      ID_WADR = 7'h00;
      ID_WDATA = 8'h00;
      DS_PRESENT = 2'h0;
      OWN_CAP = {8'h0A, 5'h04};
      DS_CAP = {8'h06, 5'h04, 8'h0A, 5'h02};
      repeat (12) @(negedge CLK);
      t_reset;
      t_refuse;
      t_cfg;
      t_vendor;
      t_merge;
      t_freeze;
      t_defer;
      finish_test;
   end
endmodule

// *** verilog/bcr_defs.svh ***
// constants for the branch capability relay
// assumes inclusion by bare name from bcr_pkg and design files
`ifndef BCR_DEFS_SVH
`define BCR_DEFS_SVH
`define BCR_AW 20
`define BCR_VEND_LO 20'h00300
`define BCR_VEND_HI 20'h003FF
`define BCR_CAP_RATE_ADR 20'h00001
`define BCR_CAP_LANE_ADR 20'h00002
`define BCR_CFG_RATE_ADR 20'h00100
`define BCR_CFG_LANE_ADR 20'h00101
`define BCR_LANE_MSK 8'h1F
`define BCR_RATE_162 8'h06
`define BCR_RATE_270 8'h0A
`define BCR_LANE_1 5'h01
`define BCR_LANE_2 5'h02
`define BCR_LANE_4 5'h04
`define BCR_MAX_BURST 5'h10
`define BCR_TXN_US 500
`define BCR_CLK_MHZ 125
`define BCR_TXN_CYC (`BCR_TXN_US * `BCR_CLK_MHZ)
`define BCR_ID_AW 7
`endif

// *** verilog/bcr_min_cap.sv ***
// lesser-of merge of two capability words
// assumes both inputs are legal codes or zero
`timescale 1ns/10ps
`include "bcr_defs.svh"
module bcr_min_cap (
   input wire bcr_pkg::bcr_cap_t a,
   input wire bcr_pkg::bcr_cap_t b,
   output bcr_pkg::bcr_cap_t y
);
   bcr_pkg::bcr_cap_t c;
   always_comb begin
      c.rate = (a.rate < b.rate) ? a.rate : b.rate;
      c.lanes = (a.lanes < b.lanes) ? a.lanes : b.lanes;
      // legal lane counts only; 3 falls back to 2
      if (c.lanes >= `BCR_LANE_4) begin
         c.lanes = `BCR_LANE_4;
      end else if (c.lanes >= `BCR_LANE_2) begin
         c.lanes = `BCR_LANE_2;
      end else begin
         c.lanes = `BCR_LANE_1;
      end
      if (c.rate >= `BCR_RATE_270) begin
         c.rate = `BCR_RATE_270;
      end else begin
         c.rate = `BCR_RATE_162;
      end
      y = c;
   end
endmodule

// *** verilog/bcr_pkg.sv ***
// types for the branch capability relay
// assumes bcr_defs.svh is on the include path
`include "bcr_defs.svh"
package bcr_pkg;
   typedef struct packed {
      logic [`BCR_AW-1:0] adr;
      logic [4:0] len;
      logic wr;
      logic id_space;
   } bcr_req_t;
   typedef struct packed {
      logic [7:0] rate;
      logic [4:0] lanes;
   } bcr_cap_t;
   typedef enum logic [1:0] {
      BCR_ACK,
      BCR_NACK,
      BCR_DEFER
   } bcr_resp_t;
endpackage

// *** verilog/bcr_relay.sv ***
// branch capability relay: answers upstream byte accesses to the link
// configuration data space and identification data of a branch device
// assumes an aux channel decoder presents one request at a time, and a
// downstream agent fills the identification cache and capability word
`timescale 1ns/10ps
`include "bcr_defs.svh"
module bcr_relay #(
   parameter int NPORT = 2,
   parameter int TXN_CYC = `BCR_TXN_CYC
) (
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic CE,
   input wire logic REQ_VALID,
   input wire bcr_pkg::bcr_req_t REQ,
   input wire logic [7:0] WR_DATA,
   input wire logic [NPORT-1:0] DS_PRESENT,
   input wire bcr_pkg::bcr_cap_t OWN_CAP,
   input wire bcr_pkg::bcr_cap_t [NPORT-1:0] DS_CAP,
   input wire logic ID_WE,
   input wire logic [`BCR_ID_AW-1:0] ID_WADR,
   input wire logic [7:0] ID_WDATA,
   output logic RD_VALID,
   output logic [7:0] RD_DATA,
   output logic DONE,
   output bcr_pkg::bcr_resp_t RESP,
   output logic BUSY,
   output bcr_pkg::bcr_cap_t ADV_CAP,
   output bcr_pkg::bcr_cap_t LINK_CFG,
   output logic [$clog2(NPORT)-1:0] DS_SEL
);
   typedef enum logic [1:0] {S_IDLE, S_RUN, S_END} bcr_st_t;
   localparam int IDN = 1 << `BCR_ID_AW;
   localparam int TW = $clog2(TXN_CYC + 1);
   localparam int PW = $clog2(NPORT);

   // ----------------------------------------------------------
   // pin synchronisers and downstream port choice
   // ----------------------------------------------------------
   logic [NPORT-1:0] pres_s1_r, pres_s2_r;
   logic [PW-1:0] sel_nxt, sel_r;
   logic any_r, any_nxt;
   always_comb begin
      sel_nxt = sel_r;
      any_nxt = |pres_s2_r;
      // keep current port while present, else lowest present port
      if (!pres_s2_r[sel_r]) begin
         for (int i = NPORT - 1; i >= 0; i--) begin
            if (pres_s2_r[i]) begin
               sel_nxt = PW'(i);
            end
         end
      end
   end
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         pres_s1_r <= '0;
         pres_s2_r <= '0;
         sel_r <= '0;
         any_r <= 1'b0;
      end else if (CE) begin
         pres_s1_r <= DS_PRESENT;
         pres_s2_r <= pres_s1_r;
         sel_r <= sel_nxt;
         any_r <= any_nxt;
      end
   end

   // ----------------------------------------------------------
   // capability merge
   // ----------------------------------------------------------
   bcr_pkg::bcr_cap_t merged, adv_nxt, adv_r;
   // one port feeds both identification and capability
   bcr_min_cap u_min (
      .a(OWN_CAP),
      .b(DS_CAP[sel_r]),
      .y(merged)
   );
   always_comb begin
      // no downstream sink: advertise own ability alone
      adv_nxt = any_r ? merged : OWN_CAP;
   end
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         adv_r <= '{rate: `BCR_RATE_162, lanes: `BCR_LANE_1};
      end else if (CE) begin
         adv_r <= adv_nxt;
      end
   end

   // ----------------------------------------------------------
   // identification cache, filled from the selected downstream sink
   // ----------------------------------------------------------
   logic [7:0] id_mem [IDN];
   always_ff @(posedge CLK) begin
      if (CE && ID_WE) begin
         id_mem[ID_WADR] <= ID_WDATA;
      end
   end

   // ----------------------------------------------------------
   // request engine
   // ----------------------------------------------------------
   bcr_st_t st_r, st_nxt;
   logic [`BCR_AW-1:0] adr_r, adr_nxt;
   logic [4:0] cnt_r, cnt_nxt;
   logic wr_r, wr_nxt, ids_r, ids_nxt;
   logic [TW-1:0] tmr_r, tmr_nxt;
   logic rdv_nxt, rdv_r, done_nxt, done_r;
   logic busy_nxt, busy_r;
   logic [7:0] rdd_nxt, rdd_r;
   bcr_pkg::bcr_resp_t resp_nxt, resp_r;
   bcr_pkg::bcr_cap_t cfg_nxt, cfg_r;
   logic [7:0] vend_r [256];
   logic vend_we;
   logic [7:0] lane_b;

   always_comb begin
      st_nxt = st_r;
      adr_nxt = adr_r;
      cnt_nxt = cnt_r;
      wr_nxt = wr_r;
      ids_nxt = ids_r;
      tmr_nxt = tmr_r;
      rdv_nxt = 1'b0;
      done_nxt = 1'b0;
      rdd_nxt = rdd_r;
      resp_nxt = resp_r;
      cfg_nxt = cfg_r;
      vend_we = 1'b0;
      lane_b = WR_DATA & `BCR_LANE_MSK;
      unique case (st_r)
         S_IDLE: begin
            if (REQ_VALID) begin
               adr_nxt = REQ.adr;
               wr_nxt = REQ.wr;
               ids_nxt = REQ.id_space;
               tmr_nxt = '0;
               // oversize burst is refused outright
               if (REQ.len == 5'h00 || REQ.len > `BCR_MAX_BURST) begin
                  resp_nxt = bcr_pkg::BCR_NACK;
                  st_nxt = S_END;
               end else if (REQ.id_space && !any_r) begin
                  resp_nxt = bcr_pkg::BCR_NACK;
                  st_nxt = S_END;
               end else begin
                  resp_nxt = bcr_pkg::BCR_ACK;
                  cnt_nxt = REQ.len;
                  st_nxt = S_RUN;
               end
            end
         end
         S_RUN: begin
            tmr_nxt = tmr_r + TW'(1);
            if (ids_r) begin
               rdd_nxt = id_mem[adr_r[`BCR_ID_AW-1:0]];
               rdv_nxt = !wr_r;
            end else if (wr_r) begin
               // only legal lane/rate codes take effect
               if (adr_r == `BCR_CFG_RATE_ADR &&
                   (WR_DATA == `BCR_RATE_162 ||
                    WR_DATA == `BCR_RATE_270)) begin
                  cfg_nxt.rate = WR_DATA;
               end
               if (adr_r == `BCR_CFG_LANE_ADR &&
                   (lane_b == 8'(`BCR_LANE_1) ||
                    lane_b == 8'(`BCR_LANE_2) ||
                    lane_b == 8'(`BCR_LANE_4))) begin
                  cfg_nxt.lanes = lane_b[4:0];
               end
               if (adr_r >= `BCR_VEND_LO && adr_r <= `BCR_VEND_HI) begin
                  vend_we = 1'b1;
               end
            end else begin
               rdv_nxt = 1'b1;
               if (adr_r == `BCR_CAP_RATE_ADR) begin
                  rdd_nxt = adv_r.rate;
               end else if (adr_r == `BCR_CAP_LANE_ADR) begin
                  rdd_nxt = 8'(adv_r.lanes);
               end else if (adr_r == `BCR_CFG_RATE_ADR) begin
                  rdd_nxt = cfg_r.rate;
               end else if (adr_r == `BCR_CFG_LANE_ADR) begin
                  rdd_nxt = 8'(cfg_r.lanes);
               end else if (adr_r >= `BCR_VEND_LO &&
                            adr_r <= `BCR_VEND_HI) begin
                  rdd_nxt = vend_r[adr_r[7:0]];
               end else begin
                  rdd_nxt = 8'h00;
               end
            end
            adr_nxt = adr_r + `BCR_AW'(1);
            cnt_nxt = cnt_r - 5'h01;
            if (cnt_r == 5'h01) begin
               st_nxt = S_END;
            end else if (tmr_r >= TW'(TXN_CYC - 1)) begin
               resp_nxt = bcr_pkg::BCR_DEFER;
               st_nxt = S_END;
            end
         end
         S_END: begin
            done_nxt = 1'b1;
            st_nxt = S_IDLE;
         end
         default: st_nxt = S_IDLE;
      endcase
      // kept in a flop so the pin carries no decode glitches
      busy_nxt = (st_nxt != S_IDLE);
   end

   always_ff @(posedge CLK) begin
      if (CE && vend_we) begin
         vend_r[adr_r[7:0]] <= WR_DATA;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         st_r <= S_IDLE;
         adr_r <= '0;
         cnt_r <= '0;
         wr_r <= 1'b0;
         ids_r <= 1'b0;
         tmr_r <= '0;
         rdv_r <= 1'b0;
         done_r <= 1'b0;
         rdd_r <= 8'h00;
         resp_r <= bcr_pkg::BCR_ACK;
         busy_r <= 1'b0;
         cfg_r <= '{rate: `BCR_RATE_162, lanes: `BCR_LANE_1};
      end else if (CE) begin
         st_r <= st_nxt;
         adr_r <= adr_nxt;
         cnt_r <= cnt_nxt;
         wr_r <= wr_nxt;
         ids_r <= ids_nxt;
         tmr_r <= tmr_nxt;
         rdv_r <= rdv_nxt;
         done_r <= done_nxt;
         rdd_r <= rdd_nxt;
         resp_r <= resp_nxt;
         busy_r <= busy_nxt;
         cfg_r <= cfg_nxt;
      end
   end

   assign RD_VALID = rdv_r;
   assign RD_DATA = rdd_r;
   assign DONE = done_r;
   assign RESP = resp_r;
   assign BUSY = busy_r;
   assign ADV_CAP = adv_r;
   assign LINK_CFG = cfg_r;
   assign DS_SEL = sel_r;
endmodule
